// ===== logic/rtcw_pkg.sv
// Contract
// - Without core power, time keeps counting and all but control state is kept.
// - Alarm, periodic event or external wake input can bring the device out of idle.
// - Alarm or periodic event can be driven out onto the wake pin.
// - Calendar spans one hundred years and ends at year 2099.
// - Separate second to year fields, weekday, February 29 inserted in leap years.
// - Time, calendar and alarm fields are kept and shown in BCD.
// - Alarm matches on second, minute, hour, day or weekday, or full time of day.
// - Periodic event every millisecond, second, minute, hour or day.
// - All interrupt causes merge into one processor interrupt line.
// - Count rate comes from the 32.768 kHz crystal with a calibration trim.
// - Each processor write is carried into the slow crystal timing first.
// - A written value shows only after two further crystal clock cycles.
// - With the oscillator off no register write is accepted.
// - Own power-on reset clears the block only when its supply first comes up.
// - Device reset pin and core powergood never reset these flip-flops.
// - Regulator or bandgap power-down bit shuts the core regulator off.
// - On powergood rise the system is reset, isolation ends, writes are enabled.
package rtcw_pkg;

   // Time field slots and their BCD ranges
   localparam int NUM_TM = 6;
   localparam int F_SEC = 0;
   localparam int F_MIN = 1;
   localparam int F_HOUR = 2;
   localparam int F_DATE = 3;
   localparam int F_MONTH = 4;
   localparam int F_YEAR = 5;
   localparam logic [5:0][7:0] TM_LO = {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
   localparam logic [5:0][7:0] TM_HI = {8'h99, 8'h12, 8'h31, 8'h23, 8'h59, 8'h59};
   localparam logic [5:0][7:0] TM_RST = {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] WDAY_FIRST = 8'h01;
   localparam logic [7:0] WDAY_LAST = 8'h07;
   localparam logic [7:0] WDAY_RST = 8'h01;

   // Month lengths
   localparam logic [7:0] MON_FEB = 8'h02;
   localparam logic [7:0] MON_APR = 8'h04;
   localparam logic [7:0] MON_JUN = 8'h06;
   localparam logic [7:0] MON_SEP = 8'h09;
   localparam logic [7:0] MON_NOV = 8'h11;
   localparam logic [7:0] DAYS_28 = 8'h28;
   localparam logic [7:0] DAYS_29 = 8'h29;
   localparam logic [7:0] DAYS_30 = 8'h30;
   localparam logic [7:0] DAYS_31 = 8'h31;

   // Alarm slots, also the bit positions of the alarm match mask
   localparam int NUM_ALM = 5;
   localparam int A_SEC = 0;
   localparam int A_MIN = 1;
   localparam int A_HOUR = 2;
   localparam int A_DATE = 3;
   localparam int A_WDAY = 4;

   // Prescaler: crystal ticks per second and per-tick millisecond step
   localparam logic [16:0] XTAL_PERIOD = 17'h0_8000;
   localparam logic [16:0] MS_STEP = 17'h0_03E8;
   localparam logic [9:0] MS_LAST = 10'h3E7;

   // Periodic event selections
   localparam logic [2:0] PER_OFF = 3'h0;
   localparam logic [2:0] PER_MS = 3'h1;
   localparam logic [2:0] PER_SEC = 3'h2;
   localparam logic [2:0] PER_MIN = 3'h3;
   localparam logic [2:0] PER_HOUR = 3'h4;
   localparam logic [2:0] PER_DAY = 3'h5;

   // Event flag bits
   localparam int FLG_ALARM = 0;
   localparam int FLG_PERIOD = 1;
   localparam int FLG_EXT = 2;

   // Power management register bits
   localparam int PWR_CORE_REGULATOR_POWERDOWN_BIT = 0;
   localparam int PWR_BANDGAP_POWERDOWN_BIT = 1;
   localparam int PWR_WAKE_DRV = 2;
   localparam int PWR_OSC_EN = 3;
   localparam logic [3:0] PWR_RST = 4'h8;

   // Write port targets
   typedef enum logic [4:0] {
      WS_SEC, WS_MIN, WS_HOUR, WS_DATE, WS_MONTH, WS_YEAR, WS_WDAY,
      WS_ASEC, WS_AMIN, WS_AHOUR, WS_ADATE, WS_AWDAY, WS_AMASK,
      WS_PERIOD, WS_CAL, WS_IRQ_EN, WS_FLAG_CLR, WS_PWR, WS_SCR0, WS_SCR1
   } rtcw_wsel_t;

   // Write carry-over sequence
   typedef enum logic [1:0] {SY_IDLE, SY_WAIT_A, SY_WAIT_B} rtcw_sync_t;

   typedef struct packed {
      logic [5:0][7:0] tm;
      logic [7:0] wday;
      logic [4:0][7:0] alm;
      logic [4:0] alm_mask;
      logic [2:0] per_sel;
      logic [7:0] cal;
      logic [2:0] irq_en;
      logic [3:0] pwr;
      logic [1:0][7:0] scratch;
      logic [2:0] flags;
      logic [16:0] acc;
      logic [9:0] ms_cnt;
      rtcw_sync_t sync;
      rtcw_wsel_t p_sel;
      logic [7:0] p_data;
      logic pg;
      logic core_rst;
      logic irq;
      logic wake_oe;
   } rtcw_st_t;

   localparam rtcw_st_t ST_RST = '{
      tm: TM_RST, wday: WDAY_RST, alm: '0, alm_mask: '0, per_sel: PER_OFF,
      cal: '0, irq_en: '0, pwr: PWR_RST, scratch: '0, flags: '0, acc: '0,
      ms_cnt: '0, sync: SY_IDLE, p_sel: WS_SEC, p_data: '0, pg: 1'b0,
      core_rst: 1'b0, irq: 1'b0, wake_oe: 1'b0};

endpackage

// ===== logic/rtcw_bcd_field.sv
module rtcw_bcd_field (
   // Present value and its range
   input wire logic [7:0] cur,
   input wire logic [7:0] lo,
   input wire logic [7:0] hi,
   // Advance request
   input wire logic inc,
   // Next value and end-of-range flag
   output logic [7:0] nxt,
   output logic at_hi
);

   // Values at or above the top, left by a write, wrap to the bottom at the next step
   always_comb begin
      at_hi = (cur >= hi);
      nxt = cur;
      if (inc) begin
         if (at_hi) begin
            nxt = lo;
         end else if (cur[3:0] == 4'h9) begin
            nxt = {cur[7:4] + 4'h1, 4'h0};
         end else begin
            nxt = {cur[7:4], cur[3:0] + 4'h1};
         end
      end
   end

endmodule

// ===== logic/rtcw_calendar.sv
module rtcw_calendar (
   // Clock and own power-on reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Crystal oscillator tick, one cycle per crystal period
   input wire logic rtc_xtal_tick,
   // Core power domain
   input wire logic core_pwr_good,
   output logic core_rst_pulse,
   output logic rtc_isolate,
   output logic core_regulator_off,
   // Processor write port
   input wire logic cpu_wr_valid,
   input wire logic [4:0] cpu_wr_sel,
   input wire logic [7:0] cpu_wr_data,
   output logic cpu_wr_ready,
   // Wake pin
   input wire logic wake_request_pin_i,
   output logic wake_request_pin_o,
   output logic wake_request_pin_oe,
   // Interrupt and idle wake
   output logic rtc_irq,
   output logic idle_wake,
   // Time readback, BCD
   output logic [7:0] time_sec,
   output logic [7:0] time_min,
   output logic [7:0] time_hour,
   output logic [7:0] time_date,
   output logic [7:0] time_month,
   output logic [7:0] time_year,
   output logic [7:0] time_wday,
   // Alarm and setup readback
   output logic [7:0] alarm_sec,
   output logic [7:0] alarm_min,
   output logic [7:0] alarm_hour,
   output logic [7:0] alarm_date,
   output logic [7:0] alarm_wday,
   output logic [4:0] alarm_mask,
   output logic [2:0] periodic_sel,
   output logic [7:0] cal_trim,
   output logic [2:0] irq_enable,
   output logic [3:0] rtc_power_management_reg,
   output logic [7:0] scratch0,
   output logic [7:0] scratch1,
   output logic [2:0] event_flags
);

   rtcw_pkg::rtcw_st_t s_q;
   rtcw_pkg::rtcw_st_t s_d;
   logic osc_on;
   logic tick;
   logic [16:0] period;
   logic [16:0] acc_sum;
   logic ms_tick;
   logic sec_tick;
   logic [5:0] carry;
   logic [5:0] at_hi;
   logic [5:0][7:0] fld_hi;
   logic [5:0][7:0] fld_nxt;
   logic [7:0] wday_nxt;
   logic [7:0] days_in_month;
   logic leap;
   logic [4:0][7:0] alm_cmp;
   logic [4:0] alm_hit;
   logic alarm_set;
   logic per_set;
   logic ext_set;
   logic apply;
   logic [2:0] flag_clr;
   logic wake_cause;

   // Prescaler: a stopped oscillator freezes the count and all write traffic
   assign osc_on = s_q.pwr[rtcw_pkg::PWR_OSC_EN];
   assign tick = rtc_xtal_tick & osc_on;
   // Signed trim stretches or shortens the second in crystal ticks
   assign period = rtcw_pkg::XTAL_PERIOD + {{9{s_q.cal[7]}}, s_q.cal};
   assign acc_sum = s_q.acc + rtcw_pkg::MS_STEP;
   // Fractional accumulator gives exactly 1000 ms events per trimmed second
   assign ms_tick = tick & (acc_sum >= period);
   assign sec_tick = ms_tick & (s_q.ms_cnt == rtcw_pkg::MS_LAST);

   // Leap years: 2000..2099 only, so every year divisible by four
   always_comb begin
      leap = 1'b0;
      if (!s_q.tm[rtcw_pkg::F_YEAR][4]) begin
         leap = (s_q.tm[rtcw_pkg::F_YEAR][3:0] == 4'h0) ||
                (s_q.tm[rtcw_pkg::F_YEAR][3:0] == 4'h4) ||
                (s_q.tm[rtcw_pkg::F_YEAR][3:0] == 4'h8);
      end else begin
         leap = (s_q.tm[rtcw_pkg::F_YEAR][3:0] == 4'h2) ||
                (s_q.tm[rtcw_pkg::F_YEAR][3:0] == 4'h6);
      end
   end

   // Length of the present month, in BCD
   always_comb begin
      days_in_month = rtcw_pkg::DAYS_31;
      case (s_q.tm[rtcw_pkg::F_MONTH])
         rtcw_pkg::MON_FEB: begin
            days_in_month = leap ? rtcw_pkg::DAYS_29 : rtcw_pkg::DAYS_28;
         end
         rtcw_pkg::MON_APR, rtcw_pkg::MON_JUN, rtcw_pkg::MON_SEP, rtcw_pkg::MON_NOV: begin
            days_in_month = rtcw_pkg::DAYS_30;
         end
         default: begin
            days_in_month = rtcw_pkg::DAYS_31;
         end
      endcase
   end

   assign carry[0] = sec_tick;

   // Ripple of BCD fields; year wraps 99 to 00 with no further carry
   for (genvar i = 0; i < rtcw_pkg::NUM_TM; i++) begin : g_fld
      // Date range follows the month; hours stop at 23
      assign fld_hi[i] = (i == rtcw_pkg::F_DATE) ? days_in_month : rtcw_pkg::TM_HI[i];
      rtcw_bcd_field u_fld (
         .cur(s_q.tm[i]),
         .lo(rtcw_pkg::TM_LO[i]),
         .hi(fld_hi[i]),
         .inc(carry[i]),
         .nxt(fld_nxt[i]),
         .at_hi(at_hi[i])
      );
      if (i < rtcw_pkg::NUM_TM - 1) begin : g_c
         assign carry[i + 1] = carry[i] & at_hi[i];
      end
   end

   // Weekday steps with each new day, 1 to 7
   always_comb begin
      wday_nxt = s_q.wday;
      if (carry[rtcw_pkg::F_DATE]) begin
         if (s_q.wday >= rtcw_pkg::WDAY_LAST) begin
            wday_nxt = rtcw_pkg::WDAY_FIRST;
         end else begin
            wday_nxt = s_q.wday + 8'h01;
         end
      end
   end

   // Alarm compares against the time that the second tick produces
   assign alm_cmp = {wday_nxt, fld_nxt[rtcw_pkg::F_DATE], fld_nxt[rtcw_pkg::F_HOUR],
                     fld_nxt[rtcw_pkg::F_MIN], fld_nxt[rtcw_pkg::F_SEC]};
   for (genvar a = 0; a < rtcw_pkg::NUM_ALM; a++) begin : g_alm
      assign alm_hit[a] = ~s_q.alm_mask[a] | (s_q.alm[a] == alm_cmp[a]);
   end
   // An all-clear mask means the alarm is off, never an every-second match
   assign alarm_set = sec_tick & (|s_q.alm_mask) & (&alm_hit);

   // Periodic source selection
   always_comb begin
      case (s_q.per_sel)
         rtcw_pkg::PER_MS: per_set = ms_tick;
         rtcw_pkg::PER_SEC: per_set = sec_tick;
         rtcw_pkg::PER_MIN: per_set = carry[rtcw_pkg::F_MIN];
         rtcw_pkg::PER_HOUR: per_set = carry[rtcw_pkg::F_HOUR];
         rtcw_pkg::PER_DAY: per_set = carry[rtcw_pkg::F_DATE];
         default: per_set = 1'b0;
      endcase
   end

   // Wake input is sampled once per crystal period; our own drive is not seen
   assign ext_set = tick & wake_request_pin_i & ~s_q.wake_oe;

   // A pending write lands on the second crystal tick after it was taken
   assign apply = tick & (s_q.sync == rtcw_pkg::SY_WAIT_B) & core_pwr_good;
   assign flag_clr = (apply && s_q.p_sel == rtcw_pkg::WS_FLAG_CLR) ? s_q.p_data[2:0] : 3'h0;

   // Writes need core power up, oscillator running and no write in flight.
   // One write at a time keeps the slow carry-over safe at any core clock ratio.
   assign cpu_wr_ready = (s_q.sync == rtcw_pkg::SY_IDLE) & s_q.pg & osc_on;

   // Causes that restore core power from RTC-only operation
   assign wake_cause = ext_set |
                       (s_q.pwr[rtcw_pkg::PWR_WAKE_DRV] & (alarm_set | per_set));

   always_comb begin
      s_d = s_q;
      // Powergood edge: system reset pulse, isolation follows the flop
      s_d.pg = core_pwr_good;
      s_d.core_rst = core_pwr_good & ~s_q.pg;

      // Prescaler and time counting, running whatever the core does
      if (tick) begin
         s_d.acc = ms_tick ? (acc_sum - period) : acc_sum;
      end
      if (ms_tick) begin
         s_d.ms_cnt = sec_tick ? 10'h000 : s_q.ms_cnt + 10'h001;
      end
      s_d.tm = fld_nxt;
      s_d.wday = wday_nxt;

      // Write carry-over sequence
      case (s_q.sync)
         rtcw_pkg::SY_IDLE: begin
            if (cpu_wr_valid && cpu_wr_ready) begin
               s_d.p_sel = rtcw_pkg::rtcw_wsel_t'(cpu_wr_sel);
               s_d.p_data = cpu_wr_data;
               s_d.sync = rtcw_pkg::SY_WAIT_A;
            end
         end
         rtcw_pkg::SY_WAIT_A: begin
            if (tick) begin
               s_d.sync = rtcw_pkg::SY_WAIT_B;
            end
         end
         rtcw_pkg::SY_WAIT_B: begin
            if (tick) begin
               s_d.sync = rtcw_pkg::SY_IDLE;
            end
         end
         default: begin
            s_d.sync = rtcw_pkg::SY_IDLE;
         end
      endcase

      // Landing a write; it overrides a count step in the same cycle
      if (apply) begin
         case (s_q.p_sel)
            rtcw_pkg::WS_SEC: begin
               // Setting seconds restarts the running second
               s_d.tm[rtcw_pkg::F_SEC] = s_q.p_data;
               s_d.acc = '0;
               s_d.ms_cnt = '0;
            end
            rtcw_pkg::WS_MIN: s_d.tm[rtcw_pkg::F_MIN] = s_q.p_data;
            rtcw_pkg::WS_HOUR: s_d.tm[rtcw_pkg::F_HOUR] = s_q.p_data;
            rtcw_pkg::WS_DATE: s_d.tm[rtcw_pkg::F_DATE] = s_q.p_data;
            rtcw_pkg::WS_MONTH: s_d.tm[rtcw_pkg::F_MONTH] = s_q.p_data;
            rtcw_pkg::WS_YEAR: s_d.tm[rtcw_pkg::F_YEAR] = s_q.p_data;
            rtcw_pkg::WS_WDAY: s_d.wday = s_q.p_data;
            rtcw_pkg::WS_ASEC: s_d.alm[rtcw_pkg::A_SEC] = s_q.p_data;
            rtcw_pkg::WS_AMIN: s_d.alm[rtcw_pkg::A_MIN] = s_q.p_data;
            rtcw_pkg::WS_AHOUR: s_d.alm[rtcw_pkg::A_HOUR] = s_q.p_data;
            rtcw_pkg::WS_ADATE: s_d.alm[rtcw_pkg::A_DATE] = s_q.p_data;
            rtcw_pkg::WS_AWDAY: s_d.alm[rtcw_pkg::A_WDAY] = s_q.p_data;
            rtcw_pkg::WS_AMASK: s_d.alm_mask = s_q.p_data[4:0];
            rtcw_pkg::WS_PERIOD: s_d.per_sel = s_q.p_data[2:0];
            rtcw_pkg::WS_CAL: s_d.cal = s_q.p_data;
            rtcw_pkg::WS_IRQ_EN: s_d.irq_en = s_q.p_data[2:0];
            rtcw_pkg::WS_PWR: s_d.pwr = s_q.p_data[3:0];
            rtcw_pkg::WS_SCR0: s_d.scratch[0] = s_q.p_data;
            rtcw_pkg::WS_SCR1: s_d.scratch[1] = s_q.p_data;
            default: begin
               s_d.p_data = s_q.p_data;
            end
         endcase
      end

      // Sticky event flags; a new event beats a clear in the same cycle
      s_d.flags = (s_q.flags & ~flag_clr) | {ext_set, per_set, alarm_set};

      // While the core is down, power-down bits drop on a wake cause
      if (!core_pwr_good && wake_cause) begin
         s_d.pwr[rtcw_pkg::PWR_CORE_REGULATOR_POWERDOWN_BIT] = 1'b0;
         s_d.pwr[rtcw_pkg::PWR_BANDGAP_POWERDOWN_BIT] = 1'b0;
      end

      // Control state is not kept without core power; in-flight write is lost
      if (!core_pwr_good) begin
         s_d.irq_en = '0;
         s_d.sync = rtcw_pkg::SY_IDLE;
      end

      // One merged interrupt line, and the wake pin drive
      s_d.irq = |(s_d.flags & s_d.irq_en);
      s_d.wake_oe = s_d.pwr[rtcw_pkg::PWR_WAKE_DRV] &
                    (s_d.flags[rtcw_pkg::FLG_ALARM] | s_d.flags[rtcw_pkg::FLG_PERIOD]);
   end

   // Only the block's own supply reset is wired here, never a device reset
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q <= rtcw_pkg::ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Core domain outputs
   assign core_rst_pulse = s_q.core_rst;
   assign rtc_isolate = ~s_q.pg;
   assign core_regulator_off = s_q.pwr[rtcw_pkg::PWR_CORE_REGULATOR_POWERDOWN_BIT] |
                               s_q.pwr[rtcw_pkg::PWR_BANDGAP_POWERDOWN_BIT];

   // Wake pin drives high only while enabled
   assign wake_request_pin_o = 1'b1;
   assign wake_request_pin_oe = s_q.wake_oe;

   // Interrupt and idle wake
   assign rtc_irq = s_q.irq;
   assign idle_wake = |s_q.flags;

   // Readback
   assign time_sec = s_q.tm[rtcw_pkg::F_SEC];
   assign time_min = s_q.tm[rtcw_pkg::F_MIN];
   assign time_hour = s_q.tm[rtcw_pkg::F_HOUR];
   assign time_date = s_q.tm[rtcw_pkg::F_DATE];
   assign time_month = s_q.tm[rtcw_pkg::F_MONTH];
   assign time_year = s_q.tm[rtcw_pkg::F_YEAR];
   assign time_wday = s_q.wday;
   assign alarm_sec = s_q.alm[rtcw_pkg::A_SEC];
   assign alarm_min = s_q.alm[rtcw_pkg::A_MIN];
   assign alarm_hour = s_q.alm[rtcw_pkg::A_HOUR];
   assign alarm_date = s_q.alm[rtcw_pkg::A_DATE];
   assign alarm_wday = s_q.alm[rtcw_pkg::A_WDAY];
   assign alarm_mask = s_q.alm_mask;
   assign periodic_sel = s_q.per_sel;
   assign cal_trim = s_q.cal;
   assign irq_enable = s_q.irq_en;
   assign rtc_power_management_reg = s_q.pwr;
   assign scratch0 = s_q.scratch[0];
   assign scratch1 = s_q.scratch[1];
   assign event_flags = s_q.flags;

endmodule

// ===== tb/rtcw_calendar_checker.sv
module rtcw_calendar_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Inputs of the block
   input wire logic rtc_xtal_tick,
   input wire logic core_pwr_good,
   input wire logic cpu_wr_valid,
   input wire logic [4:0] cpu_wr_sel,
   input wire logic [7:0] cpu_wr_data,
   input wire logic wake_request_pin_i,
   // Outputs of the block
   input wire logic core_rst_pulse,
   input wire logic rtc_isolate,
   input wire logic core_regulator_off,
   input wire logic cpu_wr_ready,
   input wire logic wake_request_pin_o,
   input wire logic wake_request_pin_oe,
   input wire logic rtc_irq,
   input wire logic [7:0] time_sec,
   input wire logic [7:0] time_hour,
   input wire logic [2:0] irq_enable,
   input wire logic [3:0] rtc_power_management_reg,
   input wire logic [7:0] scratch0,
   input wire logic [2:0] event_flags
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic pend_q;
   logic [1:0] cnt_q;
   logic [4:0] sel_q;
   logic [7:0] dat_q;
   wire acc_w = cpu_wr_valid && cpu_wr_ready;
   // Track the write in flight; a power loss drops it
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !core_pwr_good) begin
         pend_q <= 1'b0;
         cnt_q <= 2'd0;
      end else if (acc_w) begin
         pend_q <= 1'b1;
         cnt_q <= 2'd0;
         sel_q <= cpu_wr_sel;
         dat_q <= cpu_wr_data;
      end else if (pend_q && cpu_wr_ready) begin
         pend_q <= 1'b0;
      end else if (pend_q && rtc_xtal_tick && cnt_q != 2'd3) begin
         cnt_q <= cnt_q + 2'd1;
      end
   end
   property p_rst_pulse;
      $rose(core_pwr_good) |=> core_rst_pulse ##1 !core_rst_pulse;
   endproperty
   property p_isolate;
      $fell(core_pwr_good) |=> rtc_isolate && !cpu_wr_ready;
   endproperty
   property p_osc_off;
      !rtc_power_management_reg[rtcw_pkg::PWR_OSC_EN] |-> !cpu_wr_ready;
   endproperty
   property p_one_wr;
      acc_w |=> !cpu_wr_ready;
   endproperty
   property p_land_cnt;
      pend_q && cpu_wr_ready |-> cnt_q == 2'd2;
   endproperty
   property p_land_due;
      pend_q && cnt_q == 2'd2 && core_pwr_good && rtc_power_management_reg[3] |-> cpu_wr_ready;
   endproperty
   property p_scr_val;
      pend_q && cpu_wr_ready && sel_q == 5'd18 |-> scratch0 == dat_q;
   endproperty
   property p_scr_hold;
      pend_q && !cpu_wr_ready |-> $stable(scratch0);
   endproperty
   property p_irq;
      rtc_irq == |(event_flags & irq_enable);
   endproperty
   property p_wake_out;
      wake_request_pin_oe |-> event_flags[1:0] != 2'b00 && wake_request_pin_o;
   endproperty
   property p_ext;
      rtc_xtal_tick && wake_request_pin_i && !wake_request_pin_oe |=> event_flags[2];
   endproperty
   property p_reg_off;
      core_regulator_off == (rtc_power_management_reg[1:0] != 2'b00);
   endproperty
   property p_hour;
      time_hour <= 8'h23 && time_hour[3:0] <= 4'h9 && time_sec[3:0] <= 4'h9;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse wrong");
   a_isolate: assert property (p_isolate) else $error("isolation late");
   a_osc_off: assert property (p_osc_off) else $error("write taken, osc off");
   a_one_wr: assert property (p_one_wr) else $error("ready stayed high");
   a_land_cnt: assert property (p_land_cnt) else $error("landed early");
   a_land_due: assert property (p_land_due) else $error("landing late");
   a_scr_val: assert property (p_scr_val) else $error("scratch value wrong");
   a_scr_hold: assert property (p_scr_hold) else $error("value shown early");
   a_irq: assert property (p_irq) else $error("irq without cause");
   a_wake_out: assert property (p_wake_out) else $error("wake drive wrong");
   a_ext: assert property (p_ext) else $error("external wake missed");
   a_reg_off: assert property (p_reg_off) else $error("regulator wrong");
   a_hour: assert property (p_hour) else $error("hour out of range");
   c_land: cover property (pend_q && cpu_wr_ready);
   c_alarm: cover property (event_flags[0]);
   c_ext: cover property (event_flags[2]);
endmodule

bind rtcw_calendar rtcw_calendar_checker i_chk (
   .ref_clk, .sys_rst, .rtc_xtal_tick, .core_pwr_good, .cpu_wr_valid, .cpu_wr_sel,
   .cpu_wr_data, .wake_request_pin_i, .core_rst_pulse, .rtc_isolate, .core_regulator_off,
   .cpu_wr_ready, .wake_request_pin_o, .wake_request_pin_oe, .rtc_irq, .time_sec,
   .time_hour, .irq_enable, .rtc_power_management_reg, .scratch0, .event_flags
);

// ===== tb/rtcw_cpu_model.sv
module rtcw_cpu_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Request from the bench
   input wire logic req,
   input wire logic [4:0] req_sel,
   input wire logic [7:0] req_data,
   output logic done,
   // Write port toward the block
   output logic cpu_wr_valid,
   output logic [4:0] cpu_wr_sel,
   output logic [7:0] cpu_wr_data,
   input wire logic cpu_wr_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Write held until ready; released lines invert so stale use shows
   always @(posedge ref_clk) begin
      done <= 1'b0;
      if (sys_rst) begin
         cpu_wr_valid <= 1'b0;
      end else if (cpu_wr_valid && cpu_wr_ready) begin
         cpu_wr_valid <= 1'b0;
         cpu_wr_sel <= ~cpu_wr_sel;
         cpu_wr_data <= ~cpu_wr_data;
         done <= 1'b1;
      end else if (req && !cpu_wr_valid && !done) begin
         cpu_wr_valid <= 1'b1;
         cpu_wr_sel <= req_sel;
         cpu_wr_data <= req_data;
      end
   end
endmodule

// ===== tb/rtcw_calendar_tb_top.sv
module rtcw_calendar_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, sys_rst, rtc_xtal_tick, core_pwr_good, wake_request_pin_i;
   logic req, done, cpu_wr_valid, cpu_wr_ready, rtc_irq, idle_wake;
   logic core_rst_pulse, rtc_isolate, core_regulator_off, wake_request_pin_o, wake_request_pin_oe;
   logic [4:0] req_sel, cpu_wr_sel;
   logic [7:0] req_data, cpu_wr_data, scratch0, scratch1;
   logic [7:0] time_sec, time_min, time_hour, time_date, time_month, time_year, time_wday;
   logic [2:0] irq_enable, event_flags;
   logic [3:0] rtc_power_management_reg;
   int error_cnt = 0;
   int cmp_count = 0;
   int tgap = 4;
   int tcnt = 0;
   int last_nt;

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // A tick every fourth cycle keeps the clock over three times the tick rate
   always @(posedge ref_clk) begin
      tcnt = (tcnt + 1) % tgap;
      rtc_xtal_tick <= #1 (tcnt == 0);
   end

   rtcw_calendar i_dut (.ref_clk, .sys_rst, .rtc_xtal_tick, .core_pwr_good, .core_rst_pulse,
      .rtc_isolate, .core_regulator_off, .cpu_wr_valid, .cpu_wr_sel, .cpu_wr_data,
      .cpu_wr_ready, .wake_request_pin_i, .wake_request_pin_o, .wake_request_pin_oe, .rtc_irq,
      .idle_wake, .time_sec, .time_min, .time_hour, .time_date, .time_month, .time_year,
      .time_wday, .alarm_sec(), .alarm_min(), .alarm_hour(), .alarm_date(), .alarm_wday(),
      .alarm_mask(), .periodic_sel(), .cal_trim(), .irq_enable, .rtc_power_management_reg,
      .scratch0, .scratch1, .event_flags);

   rtcw_cpu_model i_cpu (.ref_clk, .sys_rst, .req, .req_sel, .req_data, .done, .cpu_wr_valid,
      .cpu_wr_sel, .cpu_wr_data, .cpu_wr_ready);

   task automatic give_verdict;
      if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic tmo;
      error_cnt++;
      $display("[FAIL] %0t ns: wait ran out", $time);
      give_verdict();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Write through the partner, then count ticks until it lands
   task automatic wr(input logic [4:0] s, input logic [7:0] d);
      int i;
      cyc(1);
      req = 1'b1;
      req_sel = s;
      req_data = d;
      i = 0;
      while (!done && i < 100) begin
         cyc(1);
         i++;
      end
      req = 1'b0;
      if (!done) tmo();
      last_nt = 0;
      i = 0;
      while (!cpu_wr_ready && rtc_power_management_reg[3] && i < 200) begin
         @(posedge ref_clk);
         if (rtc_xtal_tick) last_nt++;
         #1;
         i++;
      end
      if (i == 200) tmo();
   endtask

   task automatic t_reset_pg;
      chk(32'({time_hour, time_min, time_sec}), 32'h0000_0000);
      chk({time_year, time_month, time_date, time_wday}, 32'h0001_0101);
      chk(32'({rtc_power_management_reg, event_flags, rtc_isolate, wake_request_pin_o,
         cpu_wr_ready}), 32'h0000_0206);
      core_pwr_good = 1'b1;
      cyc(1);
      chk(32'({core_rst_pulse, rtc_isolate, cpu_wr_ready}), 32'h0000_0005);
      cyc(1);
      chk(32'(core_rst_pulse), 32'h0000_0000);
   endtask

   task automatic t_write;
      wr(5'd18, 8'h5A);
      chk(32'(last_nt), 32'h0000_0002);
      chk(32'(scratch0), 32'h0000_005A);
      wr(5'd19, 8'hA5);
      chk(32'(scratch1), 32'h0000_00A5);
   endtask

   // Leap-day midnight: alarm, daily event, trimmed second
   task automatic t_roll;
      // Select in bits 12:8, data in bits 7:0
      logic [12:0] cfg [15] = '{13'h0D05, 13'h0700, 13'h0800, 13'h0900, 13'h0C07, 13'h0F01,
         13'h110C, 13'h0524, 13'h0402, 13'h0328, 13'h0223, 13'h0159, 13'h0607, 13'h0E80,
         13'h0059};
      int n = 0;
      int i = 0;
      foreach (cfg[k]) wr(cfg[k][12:8], cfg[k][7:0]);
      chk(32'({time_hour, time_min, time_sec}), 32'h0023_5959);
      tgap = 1;
      while (time_sec === 8'h59 && i < 40000) begin
         @(posedge ref_clk);
         if (rtc_xtal_tick) n++;
         #1;
         i++;
      end
      tgap = 4;
      if (i == 40000) tmo();
      chk(32'(n > 32638 && n < 32642), 32'h0000_0001);
      cyc(2);
      chk(32'({time_hour, time_min, time_sec}), 32'h0000_0000);
      chk({time_year, time_month, time_date, time_wday}, 32'h2402_2901);
      chk(32'({event_flags, rtc_irq, wake_request_pin_oe, idle_wake}), 32'h0000_001F);
      wr(5'd16, 8'h03);
      chk(32'({event_flags, rtc_irq, wake_request_pin_oe}), 32'h0000_0000);
   endtask

   task automatic t_ms;
      int i = 0;
      wr(5'd13, 8'h01);
      while (event_flags[1] !== 1'b1 && i < 400) begin
         cyc(1);
         i++;
      end
      chk(32'(event_flags[1]), 32'h0000_0001);
      wr(5'd13, 8'h00);
      wr(5'd16, 8'h02);
      chk(32'(event_flags), 32'h0000_0000);
   endtask

   task automatic t_power;
      wr(5'd15, 8'h07);
      wr(5'd17, 8'h09);
      chk(32'(core_regulator_off), 32'h0000_0001);
      core_pwr_good = 1'b0;
      cyc(2);
      chk(32'({rtc_isolate, cpu_wr_ready, irq_enable}), 32'h0000_0010);
      // Held over two crystal periods
      wake_request_pin_i = 1'b1;
      cyc(10);
      wake_request_pin_i = 1'b0;
      chk(32'({event_flags[2], idle_wake, core_regulator_off}), 32'h0000_0006);
      chk({time_year, time_month, scratch0, 8'h00}, 32'h2402_5A00);
      core_pwr_good = 1'b1;
      cyc(1);
      chk(32'({core_rst_pulse, rtc_isolate}), 32'h0000_0002);
      wr(5'd16, 8'h04);
   endtask

   task automatic t_osc_off;
      wr(5'd17, 8'h00);
      req_sel = 5'd18;
      req_data = 8'hC3;
      req = 1'b1;
      cyc(30);
      chk(32'({done, cpu_wr_ready, scratch0}), 32'h0000_005A);
      req = 1'b0;
   endtask

   initial begin
      sys_rst = 1'b1;
      core_pwr_good = 1'b0;
      wake_request_pin_i = 1'b0;
      req = 1'b0;
      req_sel = 5'h00;
      req_data = 8'h00;
      cyc(5);
      sys_rst = 1'b0;
      cyc(1);
      t_reset_pg();
      t_write();
      t_roll();
      t_ms();
      t_power();
      t_osc_off();
      give_verdict();
   end
endmodule
